/* hw/serial_baud_gen.sv */
`timescale 1ns/1ps
module serial_baud_gen import serial_port_pkg::*; (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_arst_n,
	// divider setting
	input  wire logic       i_run,
	input  wire logic [1:0] i_prim,
	input  wire logic [2:0] i_sec,
	// one pulse per serial clock half period
	output logic            o_tick
);

	logic [5:0] pcnt_reg;  // primary stage count
	logic [5:0] pcnt_next;
	logic [2:0] scnt_reg;  // secondary stage count
	logic [2:0] scnt_next;
	logic       tick_reg;
	logic       tick_next;
	logic [5:0] ptop;      // primary terminal count
	logic [2:0] stop;      // secondary terminal count

	// ---------------------------------------------------------------
	// two chained prescalers
	// ---------------------------------------------------------------
	// primary divides by 64 >> 2*field, secondary by 8 - field
	always_comb begin
		ptop      = 6'((PRIM_DIV64 >> {i_prim, 1'b0}) - 7'h01);
		stop      = SEC_TOP - i_sec;
		pcnt_next = pcnt_reg;
		scnt_next = scnt_reg;
		tick_next = 1'b0;
		if (!i_run) begin
			// held at zero so a new transfer starts a full period
			pcnt_next = '0;
			scnt_next = '0;
		end else if (pcnt_reg == ptop) begin
			pcnt_next = '0;
			if (scnt_reg == stop) begin
				scnt_next = '0;
				tick_next = 1'b1;
			end else begin
				scnt_next = scnt_reg + 3'h1;
			end
		end else begin
			pcnt_next = pcnt_reg + 6'h01;
		end
	end

	// registers only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pcnt_reg <= '0;
			scnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			pcnt_reg <= pcnt_next;
			scnt_reg <= scnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;

endmodule

/* hw/serial_port_ctrl.sv */
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module serial_port_ctrl import serial_port_pkg::*; (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	// system
	input  wire logic        i_cpu_idle,
	output logic             o_irq,
	// serial pins
	input  wire logic        i_sck,
	output logic             o_sck,
	output logic             o_sck_oe,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	output logic             o_sdo_oe,
	input  wire logic        i_ss,
	output logic             o_ss,
	output logic             o_ss_oe
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic        en_reg, en_next;       // port_enable
	logic        sidl_reg, sidl_next;   // stop_in_idle
	logic        rov_reg, rov_next;     // receive_overflow_flag
	logic        tbf_reg, tbf_next;     // transmit_buffer_full
	logic        rbf_reg, rbf_next;     // receive_buffer_full
	logic [15:0] con1_reg, con1_next;
	logic [15:0] con2_reg, con2_next;
	logic [15:0] txh_reg, txh_next;     // transmit_holding_buffer
	logic [15:0] rxh_reg, rxh_next;     // receive_holding_buffer
	logic [2:0]  istat_reg, istat_next; // sticky interrupt status
	logic [2:0]  imask_reg, imask_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic        irq_reg, irq_next;
	eng_state_t  st_reg, st_next;
	logic [4:0]  ecnt_reg, ecnt_next;   // clock edge index
	logic [15:0] tx_sh_reg, tx_sh_next; // shift_register, out half
	logic [15:0] rx_sh_reg, rx_sh_next; // shift_register, in half
	logic        sck_reg, sck_next;
	logic        sck_oe_reg, sck_oe_next;
	logic        sdo_reg, sdo_next;
	logic        sdo_oe_reg, sdo_oe_next;
	logic        ss_reg, ss_next;
	logic        ss_oe_reg, ss_oe_next;
	logic        sck_s1, sck_s2, sck_s3; // pin synchronisers
	logic        sdi_s1, sdi_s2;
	logic        ss_s1, ss_s2;
	logic        access, wr, rd;         // bus decode
	logic [15:0] stat_view, wval;
	logic        load_ev, done_ev;       // engine events
	logic [15:0] rx_word;
	logic        run, mst, w16, fen, fsd, fdly, clock_polarity;
	logic        tick, edge_ev, lead, chg, samp, fs_act, fs_in, sel_ok;

	// byte-lane merge of a 16-bit register with a write mask
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] din, input logic [3:0] sel, input logic [15:0] wm);
		logic [15:0] lane;
		lane = {{8{sel[1]}}, {8{sel[0]}}} & wm;
		return (old & ~lane) | (din[15:0] & lane);
	endfunction

	// ---------------------------------------------------------------
	// configuration decode
	// ---------------------------------------------------------------
	assign run  = en_reg & ~(sidl_reg & i_cpu_idle);
	assign mst  = con1_reg[CON1_MST];
	assign w16  = con1_reg[CON1_W16];
	assign clock_polarity  = con1_reg[CON1_CKP];
	assign fen  = con2_reg[CON2_FEN];
	assign fsd  = con2_reg[CON2_FSD];
	assign fdly = con2_reg[CON2_FDLY];
	assign access = i_wb_cyc & i_wb_stb & ~ack_reg;
	assign wr     = access & i_wb_we;
	assign rd     = access & ~i_wb_we;
	// reserved positions forced to zero in the read view
	assign stat_view = {en_reg, 1'b0, sidl_reg, 6'h00, rov_reg, 4'h0,
		tbf_reg, rbf_reg};

	// clock divider for master mode; at rest between unframed transfers so the
	// first edge of a word comes a full half period after its load
	serial_baud_gen u_baud (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_run      (run & mst & (fen | (st_reg != ST_IDLE))),
		.i_prim     (con1_reg[CON1_PRI +: 2]),
		.i_sec      (con1_reg[CON1_SEC +: 3]),
		.o_tick     (tick)
	);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// two stages each and a third on the clock; stage two, and stage three of the clock, feed logic
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			ss_s1  <= 1'b1;
			ss_s2  <= 1'b1;
		end else begin
			sck_s1 <= i_sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sdi_s1 <= i_sdi;
			sdi_s2 <= sdi_s1;
			ss_s1  <= i_ss;
			ss_s2  <= ss_s1;
		end
	end

	// ---------------------------------------------------------------
	// bus slave, registers and flags
	// ---------------------------------------------------------------
	always_comb begin
		en_next    = en_reg;
		sidl_next  = sidl_reg;
		rov_next   = rov_reg;
		tbf_next   = tbf_reg;
		rbf_next   = rbf_reg;
		con1_next  = con1_reg;
		con2_next  = con2_reg;
		txh_next   = txh_reg;
		rxh_next   = rxh_reg;
		istat_next = istat_reg;
		imask_next = imask_reg;
		ack_next   = access;
		rdat_next  = '0;
		wval       = merge16({en_reg, 1'b0, sidl_reg, 13'h000}, i_wb_dat,
			i_wb_sel, STAT_WMASK);
		// a load empties the holding buffer; a same-cycle write refills it
		if (load_ev) begin
			tbf_next = 1'b0;
		end
		// reads: registered data, unmapped answers zero
		if (rd) begin
			case (i_wb_adr)
				OFS_STAT:  rdat_next = {16'h0000, stat_view};
				OFS_CON1:  rdat_next = {16'h0000, con1_reg};
				OFS_CON2:  rdat_next = {16'h0000, con2_reg};
				OFS_BUF: begin
					rdat_next = {16'h0000, rxh_reg};
					rbf_next  = 1'b0;
				end
				OFS_ISTAT: begin
					rdat_next  = {29'h0000000, istat_reg};
					istat_next = IRQ_RESET;
				end
				OFS_IMASK: rdat_next = {29'h0000000, imask_reg};
				default:   rdat_next = '0;
			endcase
		end
		// writes: masked so reserved bits hold zero
		if (wr) begin
			case (i_wb_adr)
				OFS_STAT: begin
					en_next   = wval[STAT_EN];
					sidl_next = wval[STAT_SIDL];
					if (i_wb_sel[0] && !i_wb_dat[STAT_ROV]) begin
						rov_next = 1'b0; // software clears overflow
					end
				end
				OFS_CON1: con1_next = merge16(con1_reg, i_wb_dat, i_wb_sel,
					CON1_WMASK);
				OFS_CON2: con2_next = merge16(con2_reg, i_wb_dat, i_wb_sel,
					CON2_WMASK);
				OFS_BUF: begin
					txh_next = merge16(txh_reg, i_wb_dat, i_wb_sel, FULL_MASK);
					tbf_next = 1'b1;
				end
				OFS_IMASK: begin
					if (i_wb_sel[0]) begin
						imask_next = i_wb_dat[2:0];
					end
				end
				default: ;
			endcase
		end
		// finished word: keep it, or drop it if buffer still unread
		if (done_ev) begin
			if (rbf_reg) begin
				rov_next = 1'b1;
				istat_next[IRQ_OV] = 1'b1;
			end else begin
				rxh_next = rx_word;
				rbf_next = 1'b1;
				istat_next[IRQ_RX] = 1'b1;
			end
		end
		if (load_ev) begin
			istat_next[IRQ_TX] = 1'b1;
		end
		irq_next = |(istat_next & imask_next);
	end

	// registers only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_reg    <= 1'b0;
			sidl_reg  <= 1'b0;
			rov_reg   <= 1'b0;
			tbf_reg   <= 1'b0;
			rbf_reg   <= 1'b0;
			con1_reg  <= REG_RESET;
			con2_reg  <= REG_RESET;
			txh_reg   <= REG_RESET;
			rxh_reg   <= REG_RESET;
			istat_reg <= IRQ_RESET;
			imask_reg <= IRQ_RESET;
			ack_reg   <= 1'b0;
			rdat_reg  <= '0;
			irq_reg   <= 1'b0;
		end else begin
			en_reg    <= en_next;
			sidl_reg  <= sidl_next;
			rov_reg   <= rov_next;
			tbf_reg   <= tbf_next;
			rbf_reg   <= rbf_next;
			con1_reg  <= con1_next;
			con2_reg  <= con2_next;
			txh_reg   <= txh_next;
			rxh_reg   <= rxh_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			ack_reg   <= ack_next;
			rdat_reg  <= rdat_next;
			irq_reg   <= irq_next;
		end
	end

	// ---------------------------------------------------------------
	// shift engine and pins
	// ---------------------------------------------------------------
	// master clock runs in a transfer, or always when framed
	assign edge_ev = mst ? (tick & ((st_reg == ST_RUN) | fen))
		: (sck_s2 ^ sck_s3);
	assign lead   = (mst ? ~sck_reg : sck_s2) != clock_polarity;
	assign chg    = (con1_reg[CON1_CKE] & ~fen) ? ~lead : lead;
	assign fs_in  = ss_s2 == con2_reg[CON2_FPOL];
	assign sel_ok = ~con1_reg[CON1_SLAVE_SELECT_ENABLE] | ~ss_s2;
	// sample at next change edge only in master mode
	assign samp   = (con1_reg[CON1_SMP] & mst)
		? ((chg & (ecnt_reg != 5'h00)) | (ecnt_reg == last_edge(w16))) : ~chg;

	always_comb begin
		st_next    = st_reg;
		ecnt_next  = ecnt_reg;
		tx_sh_next = tx_sh_reg;
		rx_sh_next = rx_sh_reg;
		sck_next   = (mst & edge_ev) ? ~sck_reg : sck_reg;
		load_ev    = 1'b0;
		done_ev    = 1'b0;
		if (!run) begin
			// off or halted: engine back to rest
			st_next  = ST_IDLE;
			ecnt_next = '0;
			sck_next = clock_polarity;
		end else begin
			unique case (st_reg)
				ST_IDLE: begin
					if (!fen) begin
						sck_next = clock_polarity;
					end
					ecnt_next = '0;
					if (fen & ~fsd) begin
						// own sync: start on a return-to-idle edge
						if (tbf_reg & edge_ev & ~lead) begin
							st_next = fdly ? ST_RUN : ST_SYNC;
							load_ev = 1'b1;
						end
					end else if (fen) begin
						// external sync seen on a leading edge
						if (edge_ev & lead & fs_in) begin
							st_next   = fdly ? ST_RUN : ST_SYNC;
							ecnt_next = 5'h01;
							load_ev   = tbf_reg;
						end
					end else if (mst) begin
						if (tbf_reg) begin
							st_next = ST_RUN;
							load_ev = 1'b1;
						end
					end else if (sel_ok) begin
						st_next = ST_RUN;
						load_ev = tbf_reg;
					end
					if (st_next != ST_IDLE) begin
						tx_sh_next = tbf_reg ? txh_reg : REG_RESET;
						rx_sh_next = REG_RESET;
					end
				end
				ST_SYNC: begin
					// one clock of sync ahead of the first bit
					if (edge_ev) begin
						if (ecnt_reg == SYNC_LAST) begin
							st_next   = ST_RUN;
							ecnt_next = '0;
						end else begin
							ecnt_next = ecnt_reg + 5'h01;
						end
					end
				end
				ST_RUN: begin
					if (!mst & !fen & con1_reg[CON1_SLAVE_SELECT_ENABLE] & ss_s2) begin
						st_next = ST_IDLE; // deselected: abandon word
					end else if (edge_ev) begin
						if (samp) begin
							rx_sh_next = {rx_sh_reg[14:0], sdi_s2};
						end
						if (chg & (ecnt_reg != 5'h00)) begin
							tx_sh_next = {tx_sh_reg[14:0], 1'b0};
						end
						if (ecnt_reg == last_edge(w16)) begin
							st_next = ST_IDLE;
							done_ev = 1'b1;
						end else begin
							ecnt_next = ecnt_reg + 5'h01;
						end
					end
				end
				default: st_next = ST_IDLE;
			endcase
		end
		rx_word = w16 ? rx_sh_next : {8'h00, rx_sh_next[7:0]};
		fs_act  = (st_next == ST_SYNC)
			| ((st_next == ST_RUN) & fdly & (ecnt_next < FS_EDGES));
		sdo_next    = w16 ? tx_sh_next[15] : tx_sh_next[7];
		sck_oe_next = run & mst & ~con1_reg[CON1_DCK];
		sdo_oe_next = run & ~con1_reg[CON1_DDO];
		ss_oe_next  = run & fen & ~fsd;
		ss_next     = con2_reg[CON2_FPOL] ? fs_act : ~fs_act;
	end

	// registers only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg     <= ST_IDLE;
			ecnt_reg   <= '0;
			tx_sh_reg  <= REG_RESET;
			rx_sh_reg  <= REG_RESET;
			sck_reg    <= 1'b0;
			sck_oe_reg <= 1'b0;
			sdo_reg    <= 1'b0;
			sdo_oe_reg <= 1'b0;
			ss_reg     <= 1'b1;
			ss_oe_reg  <= 1'b0;
		end else begin
			st_reg     <= st_next;
			ecnt_reg   <= ecnt_next;
			tx_sh_reg  <= tx_sh_next;
			rx_sh_reg  <= rx_sh_next;
			sck_reg    <= sck_next;
			sck_oe_reg <= sck_oe_next;
			sdo_reg    <= sdo_next;
			sdo_oe_reg <= sdo_oe_next;
			ss_reg     <= ss_next;
			ss_oe_reg  <= ss_oe_next;
		end
	end

	// outputs straight from flip-flops
	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
	assign o_irq    = irq_reg;
	assign o_sck    = sck_reg;
	assign o_sck_oe = sck_oe_reg;
	assign o_sdo    = sdo_reg;
	assign o_sdo_oe = sdo_oe_reg;
	assign o_ss     = ss_reg;
	assign o_ss_oe  = ss_oe_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	port_off_a: assert property (!en_reg |=> st_reg == ST_IDLE && !o_sck_oe && !o_sdo_oe)
		else $error("port off but engine or pins active");
	idle_halt_a: assert property (sidl_reg && i_cpu_idle |=> st_reg == ST_IDLE)
		else $error("engine ran during cpu idle");
	overflow_keep_a: assert property (done_ev && rbf_reg |=> rov_reg && $stable(rxh_reg))
		else $error("overflow not flagged or data replaced");
	tx_full_a: assert property (wr && i_wb_adr == OFS_BUF |=> tbf_reg)
		else $error("buffer write did not set tx full");
	tx_load_a: assert property (load_ev && !wr ##1 !load_ev |-> !tbf_reg)
		else $error("load did not clear tx full");
	rx_full_a: assert property (done_ev && !rbf_reg |=> rbf_reg && rxh_reg == $past(rx_word))
		else $error("received word not stored");
	word_len_a: assert property (done_ev |-> ecnt_reg == last_edge(w16) && st_reg == ST_RUN)
		else $error("transfer ended at wrong edge count");
	stat_zero_a: assert property (rd && i_wb_adr == OFS_STAT |=> o_wb_dat[31:16] == 16'h0000 && o_wb_dat[12:7] == 6'h00 && o_wb_dat[5:2] == 4'h0)
		else $error("reserved status bits not zero");
	sck_drive_a: assert property (run && mst && !con1_reg[CON1_DCK] |=> o_sck_oe)
		else $error("master not driving clock");
	sync_dir_a: assert property (o_ss_oe |-> $past(fen) && !$past(fsd))
		else $error("frame sync driven in input direction");

	word_done_c: cover property (done_ev && w16 && mst);
	overflow_c: cover property (done_ev && rbf_reg);
	framed_done_c: cover property (done_ev && fen);
	slave_done_c: cover property (done_ev && !mst);

endmodule

/* hw/serial_port_pkg.sv */
package serial_port_pkg;

	// ---------------------------------------------------------------
	// register byte offsets on the wishbone bus
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_STAT  = 8'h00; // port_status_control
	localparam logic [7:0] OFS_CON1  = 8'h04; // port_control_one
	localparam logic [7:0] OFS_CON2  = 8'h08; // port_control_two
	localparam logic [7:0] OFS_BUF   = 8'h0C; // data_buffer
	localparam logic [7:0] OFS_ISTAT = 8'h10; // interrupt status, read clears
	localparam logic [7:0] OFS_IMASK = 8'h14; // interrupt mask

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int STAT_EN   = 15; // port_enable
	localparam int STAT_SIDL = 13; // stop_in_idle
	localparam int STAT_ROV  = 6;  // receive_overflow_flag
	localparam int STAT_TBF  = 1;  // transmit_buffer_full
	localparam int STAT_RBF  = 0;  // receive_buffer_full
	localparam int CON1_DCK  = 12; // clock_pin_disable
	localparam int CON1_DDO  = 11; // data_out_disable
	localparam int CON1_W16  = 10; // word_width_select
	localparam int CON1_SMP  = 9;  // sample_phase
	localparam int CON1_CKE  = 8;  // clock edge select
	localparam int CON1_SLAVE_SELECT_ENABLE = 7;  // slave_select_enable
	localparam int CON1_CKP  = 6;  // clock_polarity
	localparam int CON1_MST  = 5;  // master_enable
	localparam int CON1_SEC  = 2;  // secondary_prescale lsb
	localparam int CON1_PRI  = 0;  // primary_prescale lsb
	localparam int CON2_FEN  = 15; // framed_mode_enable
	localparam int CON2_FSD  = 14; // frame_sync_direction
	localparam int CON2_FPOL = 13; // frame_sync_polarity
	localparam int CON2_FDLY = 1;  // frame_sync_delay
	localparam int IRQ_RX    = 0;  // receive complete
	localparam int IRQ_TX    = 1;  // holding buffer emptied
	localparam int IRQ_OV    = 2;  // receive overflow

	// ---------------------------------------------------------------
	// masks, reset values, counts
	// ---------------------------------------------------------------
	localparam logic [15:0] STAT_WMASK = 16'hA000; // writable control bits
	localparam logic [15:0] CON1_WMASK = 16'h1FFF;
	localparam logic [15:0] CON2_WMASK = 16'hE002;
	localparam logic [15:0] FULL_MASK  = 16'hFFFF;
	localparam logic [15:0] REG_RESET  = 16'h0000;
	localparam logic [2:0]  IRQ_RESET  = 3'h0;
	localparam int          BITS_BYTE  = 8;
	localparam int          BITS_WORD  = 16;
	localparam logic [4:0]  LAST_BYTE  = 5'(2 * BITS_BYTE - 1);
	localparam logic [4:0]  LAST_WORD  = 5'(2 * BITS_WORD - 1);
	localparam logic [4:0]  SYNC_LAST  = 5'h01; // index of the last edge of a frame sync lead
	localparam logic [4:0]  FS_EDGES   = 5'h02; // edges of a coincident sync
	localparam logic [6:0]  PRIM_DIV64 = 7'h40;
	localparam logic [2:0]  SEC_TOP    = 3'h7;

	// engine states, gray along idle -> sync -> run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SYNC = 2'b01,
		ST_RUN  = 2'b11
	} eng_state_t;

	// index of the last clock edge of a transfer
	function automatic logic [4:0] last_edge(input logic w16);
		return w16 ? LAST_WORD : LAST_BYTE;
	endfunction

endpackage

/* sim/spi_partner.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far-side peripheral: loops data back, never selects the port
// ---------------------------------------------------------------
module spi_partner (
	// pins as the port drives them
	input  wire logic i_sck,
	input  wire logic i_sck_oe,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe,
	// line levels seen by the port
	output logic      o_sck,
	output logic      o_sdi,
	output logic      o_ss
);
	logic last_sdo = 1'b0; // last level driven on data out
	logic last_sck = 1'b0; // last level driven on the clock
	// remember last driven levels, a released line shows their inverse
	always @(i_sdo or i_sdo_oe or i_sck or i_sck_oe) begin
		if (i_sdo_oe) begin
			last_sdo = i_sdo;
		end
		if (i_sck_oe) begin
			last_sck = i_sck;
		end
	end
	// clock line follows the master, data echoes straight back
	assign o_sck = i_sck_oe ? i_sck : ~last_sck;
	assign o_sdi = i_sdo_oe ? i_sdo : ~last_sdo;
	// select held at its pull-up, frame sync never sent
	assign o_ss  = 1'b1;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb_top import serial_port_pkg::*;;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic i_core_clk = 1'b0, i_arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, irq, sck, sck_oe, sdo, sdo_oe, ss, ss_oe, sdi, sck_in, ss_in;
	logic [15:0] q;
	int mismatches = 0, comparisons = 0, n;
	typedef struct packed { logic [7:0] a; logic [15:0] w; logic [15:0] e; } row_t;
	row_t rows[4] = '{'{OFS_CON1, 16'hFFFF, 16'h1FFF}, '{OFS_CON2, 16'hFFFF, 16'hE002},
		'{OFS_STAT, 16'h7FFF, 16'h2000}, '{8'h18, 16'hFFFF, 16'h0000}};
	logic [15:0] ps[5] = '{16'h003B, 16'h003E, 16'h003D, 16'h0023, 16'h0020}; // control one
	int half_exp[5] = '{2, 4, 16, 8, 512}; // core cycles per half clock
	// ---------------------------------------------------------------
	// design, far side, clock
	// ---------------------------------------------------------------
	serial_port_ctrl serial_port_ctrl_inst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat), .i_cpu_idle(idle), .o_irq(irq),
		.i_sck(sck_in), .o_sck(sck), .o_sck_oe(sck_oe), .i_sdi(sdi), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .i_ss(ss_in), .o_ss(ss), .o_ss_oe(ss_oe));
	spi_partner spi_partner_inst (.i_sck(sck), .i_sck_oe(sck_oe), .i_sdo(sdo),
		.i_sdo_oe(sdo_oe), .o_sck(sck_in), .o_sdi(sdi), .o_ss(ss_in));
	initial begin
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge i_core_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {16'h0, d}; sel <= 4'h3;
		do begin @(posedge i_core_clk); k++; end while (ack !== 1'b1 && k < 50);
		q = rdat[15:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (k >= 50) mismatches++;
	endtask
	// poll status until the given bit is set
	task automatic wait_stat(input int b);
		int k;
		k = 0;
		do begin wb(1'b0, OFS_STAT, 16'h0); k++; end while (q[b] !== 1'b1 && k < 4000);
		if (q[b] !== 1'b1) mismatches++;
	endtask
	// core cycles between two clock pin changes
	task automatic half(output int m);
		logic s;
		s = sck; m = 0;
		while (sck === s && m < 9000) begin @(posedge i_core_clk); m++; end
		s = sck; m = 0;
		while (sck === s && m < 9000) begin @(posedge i_core_clk); m++; end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_core_clk);
		`CHK("oe in reset", 3'b000, {sck_oe, sdo_oe, ss_oe})
		i_arst_n <= 1'b1;
		wb(1'b0, OFS_STAT, 16'h0); `CHK("stat reset", REG_RESET, q)
		wb(1'b0, OFS_CON1, 16'h0); `CHK("con1 reset", REG_RESET, q)
		// masks of writable bits and an unmapped place
		foreach (rows[i]) begin
			wb(1'b1, rows[i].a, rows[i].w);
			wb(1'b0, rows[i].a, 16'h0); `CHK("reg mask", rows[i].e, q)
		end
		wb(1'b1, OFS_CON2, 16'h0);
		// data checks at four core cycles per half clock: the input synchroniser
		// needs more than two cycles between a data change and its sample
		wb(1'b1, OFS_CON1, 16'h003E);
		wb(1'b1, OFS_IMASK, 16'h0004);
		wb(1'b1, OFS_STAT, 16'h8000);
		// back-to-back loads: second waits in the holding buffer
		wb(1'b1, OFS_BUF, 16'h00A5);
		wb(1'b1, OFS_BUF, 16'h003C);
		wb(1'b0, OFS_STAT, 16'h0); `CHK("tx full", 16'h8002, q)
		wait_stat(STAT_RBF);
		wb(1'b0, OFS_BUF, 16'h0); `CHK("byte rx", 16'h00A5, q)
		wait_stat(STAT_RBF);
		// third byte lands on an unread buffer
		wb(1'b1, OFS_BUF, 16'h005A);
		wait_stat(STAT_ROV);
		`CHK("ovf stat", 16'h8041, q)
		`CHK("irq on", 1'b1, irq)
		wb(1'b0, OFS_BUF, 16'h0); `CHK("kept data", 16'h003C, q)
		wb(1'b0, OFS_ISTAT, 16'h0); `CHK("istat ovf", 1'b1, q[IRQ_OV])
		repeat (2) @(posedge i_core_clk);
		`CHK("irq cleared", 1'b0, irq)
		wb(1'b1, OFS_STAT, 16'h8000);
		wb(1'b0, OFS_STAT, 16'h0); `CHK("ovf clear", 16'h8000, q)
		// word transfer
		wb(1'b1, OFS_CON1, 16'h043E);
		wb(1'b1, OFS_BUF, 16'hBEEF);
		wait_stat(STAT_RBF);
		wb(1'b0, OFS_BUF, 16'h0); `CHK("word rx", 16'hBEEF, q)
		// word with late sample and change on return-to-idle edges
		wb(1'b1, OFS_CON1, 16'h073E);
		wb(1'b1, OFS_BUF, 16'h5AC3);
		wait_stat(STAT_RBF);
		wb(1'b0, OFS_BUF, 16'h0); `CHK("late sample", 16'h5AC3, q)
		// framed master: free clock, own sync idle high, edge select zero
		wb(1'b1, OFS_CON1, 16'h003E);
		wb(1'b1, OFS_CON2, 16'h8000);
		repeat (2) @(posedge i_core_clk);
		`CHK("sync out", 2'b11, {ss_oe, ss})
		half(n); `CHK("free clock", 4, n)
		wb(1'b1, OFS_BUF, 16'h0096);
		wait_stat(STAT_RBF);
		wb(1'b0, OFS_BUF, 16'h0); `CHK("framed rx", 16'h0096, q)
		wb(1'b1, OFS_CON2, 16'h0000);
		// prescaler settings, never both at one to one
		foreach (ps[i]) begin
			wb(1'b1, OFS_CON1, ps[i]);
			wb(1'b1, OFS_BUF, 16'h0000);
			half(n); `CHK("half period", half_exp[i], n)
			wait_stat(STAT_RBF);
			wb(1'b0, OFS_BUF, 16'h0);
		end
		// idle clock level high, master drives it
		wb(1'b1, OFS_CON1, 16'h007B);
		repeat (3) @(posedge i_core_clk);
		`CHK("idle level", 2'b11, {sck_oe, sck})
		// stop in idle
		wb(1'b1, OFS_STAT, 16'hA000);
		idle <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		`CHK("idle halt", 1'b0, sck_oe)
		idle <= 1'b0;
		wb(1'b1, OFS_STAT, 16'h8000);
		idle <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		`CHK("idle run", 1'b1, sck_oe)
		idle <= 1'b0;
		wb(1'b1, OFS_STAT, 16'h0000);
		repeat (3) @(posedge i_core_clk);
		`CHK("port off", 2'b00, {sck_oe, sdo_oe})
		// reset in mid-run clears pins and registers
		wb(1'b1, OFS_CON1, 16'h003E);
		wb(1'b1, OFS_STAT, 16'h8000);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		`CHK("oe mid reset", 3'b000, {sck_oe, sdo_oe, ss_oe})
		i_arst_n <= 1'b1;
		wb(1'b0, OFS_CON1, 16'h0); `CHK("con1 mid reset", REG_RESET, q)
		wb(1'b0, OFS_STAT, 16'h0); `CHK("stat mid reset", REG_RESET, q)
		give_verdict();
	end
endmodule
